// ==== hdl/cdc_datapath_control.sv ====
// Function
// - subtract a running per-channel dc offset estimate from decimated record data
// - hold bit freezes the estimate, which is still subtracted
// - after reset line input is selected and gain is 0 dB
// - gain per channel spans plus/minus 12 dB in 0.5 dB steps
// - clearing power-down ramps quiescent level up over about 200 ms
// - playback stays silent for 2000 frames after power-up release
// - playback forced to zero while a clock change is in progress
// - source bit selects which of two serial inputs feeds playback
// - de-emphasis tuned for 44.1 kHz, scales with sample rate
// - de-emphasis only applied in single-speed range
// - loopback routes record samples into playback instead of serial input
// - in loopback playback format is ignored, applied once loopback clears
// - in loopback serial output keeps record data in record format
// - mute asserted in power-up, reset, mute, power-down, bad clock ratio
// - mute output active low, driven
// - power-down bit set after reset, registers usable
// - three speed ranges single, double and quad
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.svh"
module cdc_datapath_control
  import cdc_pkg::*;
#(
  parameter int W        = 24,
  parameter int RAMP_CYC = `CDC_RAMP_CYC
)(
  // system clock and reset
  input  wire  logic                clk_sys,
  input  wire  logic                rst_n,
  // register port
  input  wire  logic [7:0]          reg_addr,
  input  wire  logic [7:0]          reg_wdata,
  input  wire  logic                reg_we,
  output logic [7:0]                reg_rdata,
  // record samples from decimator
  input  wire  logic                adc_valid,
  input  wire  logic signed [W-1:0] adc_left,
  input  wire  logic signed [W-1:0] adc_right,
  // playback samples to converter
  output logic                      pb_valid,
  output logic [W-1:0]              pb_left,
  output logic [W-1:0]              pb_right,
  output logic                      deemph_en,
  output logic [1:0]                speed_mode,
  // analog controls
  output logic                      mic_select,
  output logic [5:0]                gain_left,
  output logic [5:0]                gain_right,
  output logic [7:0]                quiescent_reference,
  output logic                      mute_control_out_n,
  // clock supervision pins
  input  wire  logic                clk_ratio_bad,
  input  wire  logic                clk_change_busy,
  // serial link
  input  wire  logic                sclk,
  input  wire  logic                frame_clock,
  input  wire  logic                serial_audio_in_a,
  input  wire  logic                serial_audio_in_b,
  output logic                      serial_audio_out
);
  localparam int STEP = (RAMP_CYC / 256 > 1) ? RAMP_CYC / 256 : 1;
  // ****************
  // system state
  // ****************
  logic [7:0]   pwr_r, pwr_nxt, pbf_r, pbf_nxt, recf_r, recf_nxt, rt_r, rt_nxt;
  logic [7:0]   grr_r, grr_nxt, grl_r, grl_nxt, rd_r, rd_nxt, vq_r, vq_nxt;
  logic [1:0]   eff_r, eff_nxt;
  cdc_pwr_t     st_r, st_nxt;
  logic [23:0]  div_r, div_nxt;
  logic [10:0]  hc_r, hc_nxt;
  logic         pv_r, pv_nxt, de_r, de_nxt, mu_r, mu_nxt;
  logic [W-1:0] pl_r, pl_nxt, pr_r, pr_nxt, rl_r, rl_nxt, rr_r, rr_nxt;
  logic [5:0]   gl_r, gl_nxt, gr_r, gr_nxt;
  logic         pack_r, pack_nxt, rreq_r, rreq_nxt;
  logic [1:0]   s_bad, s_chg, s_preq, s_rack;
  logic [1:0]   hv;
  logic [W-1:0] hd [2];
  logic         pb_new, zero, tick, lp;
  // ****************
  // link state
  // ****************
  logic [1:0]   l_rst, l_fmt0, l_fmt1, l_src, l_rf, l_rreq, l_pack;
  logic         fc_r, fc_nxt, half_r, half_nxt, lpreq_r, lpreq_nxt, lrack_r, lrack_nxt;
  logic [5:0]   cnt_r, cnt_nxt;
  logic [W-1:0] sh_r, sh_nxt, wl_r, wl_nxt, xl_r, xl_nxt, xr_r, xr_nxt;
  logic [W-1:0] tl_r, tl_nxt, tr_r, tr_nxt;
  logic [W:0]   tx_r, tx_nxt;
  logic         din, edg, i2s, ri2s;

  function automatic logic [5:0] clampg(input logic [7:0] g);
    if ($signed(g) > `CDC_GAIN_MAX)
      clampg = 6'(`CDC_GAIN_MAX);
    else if ($signed(g) < -`CDC_GAIN_MAX)
      clampg = 6'(-`CDC_GAIN_MAX);
    else
      clampg = g[5:0];
  endfunction : clampg

  // ****************
  // record high-pass, one per channel
  // ****************
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_hpf
      cdc_hpf #(.W(W)) u_hpf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (adc_valid),
        .in_data   (c == 0 ? adc_left : adc_right),
        .hold      (recf_r[`CDC_HOLD_BIT]),
        .out_valid (hv[c]),
        .out_data  (hd[c])
      );
    end
  endgenerate

  // ****************
  // system control
  // ****************
  always_comb
  begin
    pwr_nxt = pwr_r; pbf_nxt = pbf_r; recf_nxt = recf_r; rt_nxt = rt_r;
    grr_nxt = grr_r; grl_nxt = grl_r; vq_nxt = vq_r; st_nxt = st_r;
    div_nxt = div_r; hc_nxt = hc_r; pl_nxt = pl_r; pr_nxt = pr_r;
    rl_nxt = rl_r; rr_nxt = rr_r; pack_nxt = pack_r; rreq_nxt = rreq_r;
    if (reg_we)
    begin
      if (reg_addr == `CDC_OFS_POWER)
        pwr_nxt = reg_wdata;
      else if (reg_addr == `CDC_OFS_PB)
        pbf_nxt = reg_wdata;
      else if (reg_addr == `CDC_OFS_REC)
        recf_nxt = reg_wdata;
      else if (reg_addr == `CDC_OFS_ROUTE)
        rt_nxt = reg_wdata;
      else if (reg_addr == `CDC_OFS_GR)
        grr_nxt = reg_wdata;
      else if (reg_addr == `CDC_OFS_GL)
        grl_nxt = reg_wdata;
    end
    if (reg_addr == `CDC_OFS_POWER)
      rd_nxt = {st_r == CDC_RUN, pwr_r[6:0]};
    else if (reg_addr == `CDC_OFS_PB)
      rd_nxt = pbf_r;
    else if (reg_addr == `CDC_OFS_REC)
      rd_nxt = recf_r;
    else if (reg_addr == `CDC_OFS_ROUTE)
      rd_nxt = rt_r;
    else if (reg_addr == `CDC_OFS_GR)
      rd_nxt = grr_r;
    else if (reg_addr == `CDC_OFS_GL)
      rd_nxt = grl_r;
    else
      rd_nxt = 8'h00;
    lp = rt_r[`CDC_LOOP_BIT];
    eff_nxt = lp ? eff_r : pbf_r[`CDC_FMT_LSB +: 2];
    // quiescent ramp up when powered, discharge when down
    tick = (div_r == 24'(STEP - 1));
    div_nxt = tick ? 24'h000000 : div_r + 24'h000001;
    if (tick && !pwr_r[`CDC_PDN_BIT] && vq_r != 8'hFF)
      vq_nxt = vq_r + 8'h01;
    else if (tick && pwr_r[`CDC_PDN_BIT] && vq_r != 8'h00)
      vq_nxt = vq_r - 8'h01;
    pb_new = (s_preq[1] != pack_r);
    if (pb_new)
    begin
      pack_nxt = s_preq[1];
      pl_nxt = xl_r;
      pr_nxt = xr_r;
    end
    case (st_r)
      CDC_DOWN:
        if (!pwr_r[`CDC_PDN_BIT])
        begin
          st_nxt = CDC_WAIT;
          hc_nxt = 11'h000;
        end
      CDC_WAIT:
        if (pwr_r[`CDC_PDN_BIT])
          st_nxt = CDC_DOWN;
        else if (hc_r == 11'(`CDC_HOLD_FR))
          st_nxt = CDC_RUN;
        else if (pb_new)
          hc_nxt = hc_r + 11'h001;
      CDC_RUN:
        if (pwr_r[`CDC_PDN_BIT])
          st_nxt = CDC_DOWN;
      default:
        st_nxt = CDC_DOWN;
    endcase
    zero = s_chg[1] || st_r != CDC_RUN || pbf_r[`CDC_MUTE_BIT];
    pv_nxt = lp ? hv[0] : pb_new;
    if (pv_nxt)
    begin
      pl_nxt = zero ? '0 : (lp ? hd[0] : xl_r);
      pr_nxt = zero ? '0 : (lp ? hd[1] : xr_r);
    end
    if (hv[0] && s_rack[1] == rreq_r)
    begin
      rl_nxt = hd[0];
      rr_nxt = hd[1];
      rreq_nxt = ~rreq_r;
    end
    // 44.1 kHz curve; response tracks the frame rate
    de_nxt = pbf_r[`CDC_DEEM_BIT] && pwr_r[`CDC_SPD_LSB +: 2] == CDC_SS;
    mu_nxt = !(pwr_r[`CDC_PDN_BIT] || st_r != CDC_RUN
               || pbf_r[`CDC_MUTE_BIT] || s_bad[1]);
    gl_nxt = clampg(grl_r);
    gr_nxt = clampg(grr_r);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pwr_r <= `CDC_RST_POWER;
      pbf_r <= `CDC_RST_ZERO; recf_r <= `CDC_RST_ZERO;
      rt_r <= `CDC_RST_ZERO;
      grr_r <= `CDC_RST_ZERO; grl_r <= `CDC_RST_ZERO;
      rd_r <= 8'h00; vq_r <= 8'h00; eff_r <= 2'h0; st_r <= CDC_DOWN;
      div_r <= 24'h000000; hc_r <= 11'h000; pv_r <= 1'b0; de_r <= 1'b0;
      mu_r <= 1'b0; pl_r <= '0; pr_r <= '0; rl_r <= '0; rr_r <= '0;
      gl_r <= 6'h00; gr_r <= 6'h00; pack_r <= 1'b0; rreq_r <= 1'b0;
      s_bad <= 2'h0; s_chg <= 2'h0; s_preq <= 2'h0; s_rack <= 2'h0;
    end
    else
    begin
      pwr_r <= pwr_nxt; pbf_r <= pbf_nxt; recf_r <= recf_nxt; rt_r <= rt_nxt;
      grr_r <= grr_nxt; grl_r <= grl_nxt; rd_r <= rd_nxt; vq_r <= vq_nxt;
      eff_r <= eff_nxt; st_r <= st_nxt; div_r <= div_nxt; hc_r <= hc_nxt;
      pv_r <= pv_nxt; de_r <= de_nxt; mu_r <= mu_nxt; pl_r <= pl_nxt;
      pr_r <= pr_nxt; rl_r <= rl_nxt; rr_r <= rr_nxt; gl_r <= gl_nxt;
      gr_r <= gr_nxt; pack_r <= pack_nxt; rreq_r <= rreq_nxt;
      s_bad <= {s_bad[0], clk_ratio_bad}; s_chg <= {s_chg[0], clk_change_busy};
      s_preq <= {s_preq[0], lpreq_r}; s_rack <= {s_rack[0], lrack_r};
    end
  end

  // ****************
  // link side: receive and transmit
  // ****************
  always_comb
  begin
    i2s = (l_fmt1[1] == 1'b1) && (l_fmt0[1] == 1'b0);
    ri2s = l_rf[1];
    din = l_src[1] ? serial_audio_in_b : serial_audio_in_a;
    edg = (frame_clock != fc_r);
    fc_nxt = frame_clock;
    sh_nxt = {sh_r[W-2:0], din};
    cnt_nxt = edg ? 6'h01 : (cnt_r == 6'h3F ? cnt_r : cnt_r + 6'h01);
    half_nxt = edg ? frame_clock : half_r;
    wl_nxt = wl_r; xl_nxt = xl_r; xr_nxt = xr_r; lpreq_nxt = lpreq_r;
    if ((edg ? 6'h00 : cnt_r) == 6'(W - 1 + (i2s ? 1 : 0)))
    begin
      if (half_nxt != i2s)
        wl_nxt = sh_nxt;
      else if (l_pack[1] == lpreq_r)
      begin
        xl_nxt = wl_r;
        xr_nxt = sh_nxt;
        lpreq_nxt = ~lpreq_r;
      end
    end
    tl_nxt = tl_r; tr_nxt = tr_r; lrack_nxt = lrack_r;
    if (l_rreq[1] != lrack_r)
    begin
      tl_nxt = rl_r;
      tr_nxt = rr_r;
      lrack_nxt = l_rreq[1];
    end
    if (edg)
    begin
      if (frame_clock != ri2s)
        tx_nxt = ri2s ? {1'b0, tl_r} : {tl_r, 1'b0};
      else
        tx_nxt = ri2s ? {1'b0, tr_r} : {tr_r, 1'b0};
    end
    else
      tx_nxt = {tx_r[W-1:0], 1'b0};
  end

  always_ff @(posedge sclk)
  begin
    l_rst <= {l_rst[0], rst_n};
    if (!l_rst[1])
    begin
      fc_r <= 1'b0; half_r <= 1'b0; cnt_r <= 6'h3F; sh_r <= '0; wl_r <= '0;
      xl_r <= '0; xr_r <= '0; lpreq_r <= 1'b0; tl_r <= '0; tr_r <= '0;
      tx_r <= '0; lrack_r <= 1'b0;
      l_fmt0 <= 2'h0; l_fmt1 <= 2'h0; l_src <= 2'h0; l_rf <= 2'h0;
      l_rreq <= 2'h0; l_pack <= 2'h0;
    end
    else
    begin
      fc_r <= fc_nxt; half_r <= half_nxt; cnt_r <= cnt_nxt; sh_r <= sh_nxt;
      wl_r <= wl_nxt; xl_r <= xl_nxt; xr_r <= xr_nxt; lpreq_r <= lpreq_nxt;
      tl_r <= tl_nxt; tr_r <= tr_nxt; tx_r <= tx_nxt; lrack_r <= lrack_nxt;
      l_fmt0 <= {l_fmt0[0], eff_r[0]}; l_fmt1 <= {l_fmt1[0], eff_r[1]};
      l_src <= {l_src[0], rt_r[`CDC_SRC_BIT]};
      l_rf <= {l_rf[0], recf_r[`CDC_RFMT_BIT]};
      l_rreq <= {l_rreq[0], rreq_r}; l_pack <= {l_pack[0], pack_r};
    end
  end

  assign reg_rdata           = rd_r;
  assign pb_valid            = pv_r;
  assign pb_left             = pl_r;
  assign pb_right            = pr_r;
  assign deemph_en           = de_r;
  assign speed_mode          = pwr_r[`CDC_SPD_LSB +: 2];
  assign mic_select          = rt_r[`CDC_MIC_BIT];
  assign gain_left           = gl_r;
  assign gain_right          = gr_r;
  assign quiescent_reference = vq_r;
  assign mute_control_out_n  = mu_r;
  assign serial_audio_out    = tx_r[W];

  // ****************
  // checks
  // ****************
  a_mute_pdn: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_r[`CDC_PDN_BIT] |=> !mute_control_out_n) else $error("mute not low");
  a_zero_chg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_chg[1] |=> (!pb_valid || (pb_left == '0 && pb_right == '0)))
    else $error("data during clock change");
  a_loop_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lp && hv[0] && !zero |=> pb_valid && pb_left == $past(hd[0]))
    else $error("loopback sample lost");
  a_hold_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_r == CDC_WAIT ##1 st_r == CDC_RUN |-> $past(hc_r) == 11'(`CDC_HOLD_FR))
    else $error("holdoff length wrong");
  a_deemph_ss: assert property (@(posedge clk_sys) disable iff (!rst_n)
    deemph_en |-> $past(pwr_r[`CDC_SPD_LSB +: 2]) == CDC_SS)
    else $error("de-emphasis outside single speed");
  a_fmt_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lp |=> $stable(eff_r)) else $error("format changed in loopback");
  a_vq_ramp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && !pwr_r[`CDC_PDN_BIT] && vq_r != 8'hFF |=> vq_r == $past(vq_r) + 8'h01)
    else $error("ramp did not step");
  a_gain_span: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $signed(gain_left) <= `CDC_GAIN_MAX && $signed(gain_left) >= -`CDC_GAIN_MAX)
    else $error("gain out of span");
  a_rst_dflt: assert property (@(posedge clk_sys)
    !rst_n ##1 rst_n |-> !mic_select && gain_left == 6'h00 && pwr_r[`CDC_PDN_BIT])
    else $error("reset defaults wrong");
endmodule : cdc_datapath_control
`default_nettype wire

// ==== hdl/cdc_defs.svh ====
`ifndef CDC_DEFS_SVH
`define CDC_DEFS_SVH
// ****************
// register map
// ****************
`define CDC_OFS_POWER 8'h02
`define CDC_OFS_PB    8'h03
`define CDC_OFS_REC   8'h04
`define CDC_OFS_ROUTE 8'h06
`define CDC_OFS_GR    8'h07
`define CDC_OFS_GL    8'h08
`define CDC_RST_POWER 8'h01
`define CDC_RST_ZERO  8'h00
// ****************
// fields
// ****************
`define CDC_PDN_BIT   0
`define CDC_SPD_LSB   4
`define CDC_RDY_BIT   7
`define CDC_MUTE_BIT  0
`define CDC_DEEM_BIT  1
`define CDC_FMT_LSB   4
`define CDC_HOLD_BIT  1
`define CDC_RFMT_BIT  4
`define CDC_MIC_BIT   0
`define CDC_LOOP_BIT  1
`define CDC_SRC_BIT   7
// ****************
// timing
// ****************
`define CDC_CLK_KHZ   25000
`define CDC_RAMP_MS   200
`define CDC_RAMP_CYC  (`CDC_RAMP_MS * `CDC_CLK_KHZ)
`define CDC_HOLD_FR   2000
`define CDC_GAIN_MAX  24
`define CDC_HPF_K     10
`endif

// ==== hdl/cdc_pkg.sv ====
package cdc_pkg;
  typedef enum logic [1:0] {
    CDC_SS = 2'b00,
    CDC_DS = 2'b01,
    CDC_QS = 2'b10
  } cdc_speed_t;
  typedef enum logic [1:0] {
    CDC_DOWN = 2'b00,
    CDC_WAIT = 2'b01,
    CDC_RUN  = 2'b10
  } cdc_pwr_t;
endpackage : cdc_pkg

// ==== hdl/cdc_hpf.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.svh"
module cdc_hpf
  import cdc_pkg::*;
#(
  parameter int W = 24
)(
  // clock and reset
  input  wire  logic                clk_sys,
  input  wire  logic                rst_n,
  // sample in
  input  wire  logic                in_valid,
  input  wire  logic signed [W-1:0] in_data,
  input  wire  logic                hold,
  // sample out
  output logic                      out_valid,
  output logic signed [W-1:0]       out_data
);
  localparam int K = `CDC_HPF_K;
  logic signed [W+K-1:0] acc_r, acc_nxt;
  logic signed [W-1:0]   dat_r, dat_nxt;
  logic                  vld_r, vld_nxt;
  logic signed [W-1:0]   est;
  logic signed [W:0]     dif;

  always_comb
  begin
    est     = W'(acc_r >>> K);
    dif     = (W+1)'(in_data) - (W+1)'(est);
    acc_nxt = acc_r;
    vld_nxt = in_valid;
    dat_nxt = dat_r;
    if (in_valid)
    begin
      dat_nxt = W'(dif);
      if (!hold)
        acc_nxt = acc_r + (W+K)'(dif);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      acc_r <= '0;
      dat_r <= '0;
      vld_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      dat_r <= dat_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign out_valid = vld_r;
  assign out_data  = dat_r;

  a_hold_freezes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hold && in_valid |=> $stable(acc_r)) else $error("offset moved while held");
  a_offset_sub: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_valid |=> out_valid && out_data == W'($past(in_data) - $past(est)))
    else $error("offset not subtracted");
endmodule : cdc_hpf
`default_nettype wire

// ==== tb/cdc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdc_host_model
(
  // link clock and enable
  input  wire logic        sclk,
  input  wire logic        run,
  // words to send, left as is and right inverted
  input  wire logic [23:0] word_a,
  input  wire logic [23:0] word_b,
  // record stream back from the block
  input  wire logic        serial_audio_out,
  output logic [23:0]      rec_left,
  // serial lines
  output logic             frame_clock,
  output logic             sd_a,
  output logic             sd_b,
  output logic [15:0]      frames
);
  // ****************
  // left justified sender, 25 bits a half
  // ****************
  int cnt = 0;
  logic [23:0] rx;

  function automatic logic bit_at(input logic [23:0] w, input int c, input logic last);
    int i;
    i = c % 25;
    if (i > 23)
      return ~last;
    return (c < 25) ? w[23-i] : ~w[23-i];
  endfunction : bit_at

  initial
  begin
    frame_clock = 1'b0;
    sd_a = 1'b0;
    sd_b = 1'b1;
    frames = 16'h0000;
    rx = 24'h000000;
    rec_left = 24'h000000;
  end

  // bits change on the falling edge, so they are stable at the rising one
  always @(negedge sclk)
  begin
    if (!run)
    begin
      cnt <= 0;
      sd_a <= ~sd_a;
      sd_b <= ~sd_b;
    end
    else
    begin
      cnt <= (cnt == 49) ? 0 : cnt + 1;
      frame_clock <= (cnt < 25);
      sd_a <= bit_at(word_a, cnt, sd_a);
      sd_b <= bit_at(word_b, cnt, sd_b);
      if (cnt == 49)
        frames <= frames + 16'h0001;
      // left justified record word: msb shows one edge after the frame edge
      if (cnt >= 1 && cnt <= 24)
        rx <= {rx[22:0], serial_audio_out};
      if (cnt == 25)
        rec_left <= rx;
    end
  end
endmodule : cdc_host_model
`default_nettype wire

// ==== tb/tb_codec_datapath_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_codec_datapath_control;
  logic              clk_sys, rst_n, sclk, reg_we, adc_valid, link_run;
  logic              clk_ratio_bad, clk_change_busy, pb_valid, deemph_en;
  logic              mic_select, mute_control_out_n, frame_clock, sd_a, sd_b, serial_audio_out;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, quiescent_reference, d;
  logic signed [23:0] adc_left, adc_right;
  logic [23:0]       pb_left, pb_right, word_a, word_b, rec_left;
  logic [47:0]       o1, o2, o3, o4;
  logic [1:0]        speed_mode;
  logic [5:0]        gain_left, gain_right;
  logic [15:0]       frames, lfsr_q, f0;
  logic [7:0]        offs [5] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08};
  logic [7:0]        corner [6] = '{8'h18, 8'h19, 8'h7F, 8'h80, 8'hE8, 8'hE7};
  int                n_mismatch, checks_done, k;

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    sclk = 1'b0;
    #7;
    forever #15 sclk = ~sclk;
  end

  cdc_datapath_control #(.RAMP_CYC(512)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_left(adc_left),
    .adc_right(adc_right), .pb_valid(pb_valid), .pb_left(pb_left), .pb_right(pb_right),
    .deemph_en(deemph_en), .speed_mode(speed_mode), .mic_select(mic_select),
    .gain_left(gain_left), .gain_right(gain_right), .quiescent_reference(quiescent_reference),
    .mute_control_out_n(mute_control_out_n), .clk_ratio_bad(clk_ratio_bad),
    .clk_change_busy(clk_change_busy), .sclk(sclk), .frame_clock(frame_clock),
    .serial_audio_in_a(sd_a), .serial_audio_in_b(sd_b), .serial_audio_out(serial_audio_out));

  cdc_host_model host_u (.sclk(sclk), .run(link_run), .word_a(word_a), .word_b(word_b),
    .serial_audio_out(serial_audio_out), .rec_left(rec_left),
    .frame_clock(frame_clock), .sd_a(sd_a), .sd_b(sd_b), .frames(frames));

  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic logic [5:0] gexp(input logic [7:0] v);
    int s;
    s = $signed(v);
    if (s > 24)
      s = 24;
    if (s < -24)
      s = -24;
    return 6'(s);
  endfunction : gexp

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string w);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic stall(input string w);
    n_mismatch++;
    $display("FAIL %0t timeout %s", $time, w);
    conclude();
  endtask : stall

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    @(posedge clk_sys);
    reg_addr <= a;
    tick(1);
    chk(24'(reg_rdata), 24'(e), w);
  endtask : rd

  task automatic wait_pb;
    for (k = 0; k < 400; k++)
    begin
      tick(1);
      if (pb_valid === 1'b1)
        break;
    end
    if (k == 400)
      stall("playback strobe");
  endtask : wait_pb

  // one record pair in, looped sample back two cycles later
  task automatic adc_pulse(input logic [23:0] v, output logic [47:0] o);
    @(posedge clk_sys);
    adc_valid <= 1'b1;
    adc_left <= v;
    adc_right <= -v;
    @(posedge clk_sys);
    adc_valid <= 1'b0;
    tick(1);
    chk(24'(pb_valid), 24'h1, "loop strobe");
    o = {pb_left, pb_right};
  endtask : adc_pulse

  // ****************
  // main sequence
  // ****************
  initial
  begin
    {rst_n, reg_we, adc_valid, link_run, clk_ratio_bad, clk_change_busy} = 6'h00;
    {reg_addr, reg_wdata, adc_left, adc_right, word_a, word_b} = 112'h0;
    lfsr_q = 16'h8138;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    link_run <= 1'b1;
    rd(8'h02, 8'h01, "power reset");
    for (int i = 0; i < 5; i++)
      rd(offs[i], 8'h00, "reg reset");
    chk(24'({mic_select, gain_left, gain_right}), 24'h0, "line and 0 dB");
    chk(24'(mute_control_out_n), 24'h0, "mute in power-down");
    wr(8'h05, 8'hA5);
    rd(8'h05, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      d = (i < 6) ? corner[i] : lfsr_q[7:0];
      wr(8'h07, d);
      wr(8'h08, ~d);
      tick(2);
      chk(24'(gain_right), 24'(gexp(d)), "gain right");
      chk(24'(gain_left), 24'(gexp(~d)), "gain left");
      rd(8'h08, ~d, "gain readback");
    end
    wr(8'h06, 8'h01);
    tick(2);
    chk(24'(mic_select), 24'h1, "mic select");
    wr(8'h06, 8'h00);
    $display("test gain done");
    f0 = frames;
    wr(8'h02, 8'h00);
    tick(100);
    chk(24'(quiescent_reference > 0 && quiescent_reference < 8'hFF), 24'h1, "ramp midway");
    for (k = 0; k < 1000 && quiescent_reference !== 8'hFF; k++)
      tick(1);
    if (k == 1000)
      stall("ramp");
    chk(24'(quiescent_reference), 24'hFF, "ramp end");
    for (k = 0; k < 90000 && mute_control_out_n !== 1'b1; k++)
      tick(1);
    if (k == 90000)
      stall("hold-off");
    chk(24'(frames - f0 >= 2000 && frames - f0 <= 2004), 24'h1, "hold-off frames");
    $display("test power-up done");
    lfsr_q = lfsr_next(lfsr_q);
    word_a <= {lfsr_q, 8'h5A};
    lfsr_q = lfsr_next(lfsr_q);
    word_b <= {8'hC3, lfsr_q};
    repeat (3) wait_pb();
    chk(pb_left, word_a, "input a left");
    chk(pb_right, ~word_a, "input a right");
    wr(8'h06, 8'h80);
    repeat (3) wait_pb();
    chk(pb_left, word_b, "input b left");
    $display("test source done");
    wr(8'h06, 8'h02);
    wr(8'h03, 8'h10);
    adc_pulse(24'h180000, o1);
    chk(24'(o1[47:44]), 24'h1, "looped record sample");
    tick(120);
    chk(rec_left, 24'h180000, "serial record out");
    adc_pulse(24'h180000, o2);
    chk(24'(o2[47:24] < o1[47:24]), 24'h1, "offset tracked");
    wr(8'h04, 8'h02);
    adc_pulse(24'h180000, o3);
    adc_pulse(24'h180000, o4);
    chk(o4[47:24], o3[47:24], "frozen left");
    chk(o4[23:0], o3[23:0], "frozen right");
    wr(8'h04, 8'h00);
    adc_pulse(24'h180000, o1);
    adc_pulse(24'h180000, o2);
    chk(24'(o2[47:24] < o1[47:24]), 24'h1, "tracking resumed");
    wr(8'h03, 8'h00);
    wr(8'h06, 8'h00);
    $display("test loopback done");
    wr(8'h03, 8'h01);
    tick(3);
    chk(24'(mute_control_out_n), 24'h0, "mute bit");
    wr(8'h03, 8'h00);
    tick(3);
    chk(24'(mute_control_out_n), 24'h1, "normal high");
    clk_change_busy <= 1'b1;
    repeat (2) wait_pb();
    chk(pb_left | pb_right, 24'h0, "zero in clock change");
    clk_change_busy <= 1'b0;
    word_a <= 24'h0;
    word_b <= 24'h0;
    tick(400);
    clk_ratio_bad <= 1'b1;
    tick(5);
    chk(24'(mute_control_out_n), 24'h0, "bad ratio");
    clk_ratio_bad <= 1'b0;
    $display("test mute done");
    for (int sp = 0; sp < 3; sp++)
    begin
      wr(8'h02, 8'(sp << 4));
      wr(8'h03, 8'h02);
      tick(3);
      chk(24'(speed_mode), 24'(sp), "speed range");
      chk(24'(deemph_en), 24'(sp == 0), "de-emphasis");
    end
    wr(8'h02, 8'h01);
    tick(3);
    chk(24'(mute_control_out_n), 24'h0, "power-down mute");
    $display("test speed done");
    conclude();
  end
endmodule : tb_codec_datapath_control
`default_nettype wire
